// ---- hdl/sdm_func_map.sv ----
/*
  Digital input / output function map of the servo drive.
  Input pins are synchronised, decoded by their function codes and
  turned into control requests for the drive core; output pins are
  driven from core status as their function codes select.
  Assumes pins are asynchronous, while codes, parameters and core
  status come from logic on core_clk.
*/
module sdm_func_map
  import sdm_pkg::*;
#(
  parameter int NUM_DI = DI_COUNT,
  parameter int NUM_DO = DO_COUNT
) (
  input  wire logic                             core_clk,
  input  wire logic                             sys_rst,
  input  wire logic                             clkEn,
  input  wire logic [NUM_DI-1:0]                diPin,
  input  wire logic [NUM_DI-1:0][CODE_W-1:0]    diCode,
  input  wire logic [NUM_DO-1:0][CODE_W-1:0]    doCode,
  input  wire sdm_param_t                       param,
  input  wire sdm_core_stat_t                   coreStat,
  output logic      [NUM_DO-1:0]                doPin,
  output sdm_core_ctrl_t                        coreCtrl,
  output logic      [NUM_DI-1:0]                diState,
  output logic      [NUM_DI-1:0]                diCodeBad,
  output logic      [NUM_DO-1:0]                doCodeBad
);

  // Pins carrying a given input function
  function automatic logic [NUM_DI-1:0] diMatch(
    input logic [NUM_DI-1:0][CODE_W-1:0] codes,
    input sdm_code_t                     fn
  );
    logic [NUM_DI-1:0] hit;
    hit = '0;
    for (int i = 0; i < NUM_DI; i++) begin
      hit[i] = (codes[i] == fn);
    end
    return hit;
  endfunction : diMatch

  function automatic logic diKnown(input sdm_code_t code);
    logic ok;
    ok = 1'b0;
    case (code)
      DI_NONE, DI_ALARM_CLEAR, DI_POS_LIMIT, DI_NEG_LIMIT,
      DI_ESTOP, DI_DEV_WIPE, DI_HOME_REF: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : diKnown

  function automatic logic doKnown(input sdm_code_t code);
    logic ok;
    ok = 1'b0;
    case (code)
      DO_FORCE_OFF, DO_FORCE_ON, DO_READY, DO_FAULT_FLAG,
      DO_HOLD_BRAKE, DO_RUNNING, DO_TORQUE_CAP, DO_SPEED_CAP,
      DO_HOME_DONE, DO_DYN_BRAKE: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : doKnown

  // Level an output pin takes for its function code
  function automatic logic doLevel(
    input sdm_code_t      code,
    input sdm_core_stat_t st
  );
    logic lvl;
    lvl = 1'b0;
    case (code)
      DO_FORCE_OFF:  lvl = 1'b0;
      DO_FORCE_ON:   lvl = 1'b1;
      DO_READY:      lvl = st.mainPowerOk & ~st.alarmActive;
      DO_FAULT_FLAG: lvl = ~st.alarmActive;
      DO_HOLD_BRAKE: lvl = st.brakeRelease;
      DO_RUNNING:    lvl = st.motorRunning;
      DO_TORQUE_CAP: lvl = st.torqueAtLimit;
      DO_SPEED_CAP:  lvl = st.torqueCtrlMode & st.speedAtLimit;
      DO_HOME_DONE:  lvl = st.homingDone;
      DO_DYN_BRAKE:  lvl = st.dynBrakeReq;
      default:       lvl = 1'b0;
    endcase
    return lvl;
  endfunction : doLevel

  // Rising edge of a function level; while armed is low the edge
  // is not reported
  function automatic logic riseOf(
    input logic lvl,
    input logic prev,
    input logic armed
  );
    return lvl & ~prev & armed;
  endfunction : riseOf

  // Input synchroniser
  logic [NUM_DI-1:0] pinMeta_q;
  logic [NUM_DI-1:0] pinSync_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pinMeta_q <= {NUM_DI{PIN_RST}};
      pinSync_q <= {NUM_DI{PIN_RST}};
    end else if (clkEn) begin
      pinMeta_q <= diPin;
      pinSync_q <= pinMeta_q;
    end
  end

  // Edges other than the stop edge count only once the synchroniser and the history flops hold
  // real pin levels, so a pin held ON through reset is no OFF-to-ON
  // edge; the price is that a pin rising in these first cycles is lost
  logic [WARM_W-1:0] warm_q;
  logic              primed;

  assign primed = (warm_q == WARM_CYCLES);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      warm_q <= WARM_RST;
    end else if (clkEn && !primed) begin
      warm_q <= warm_q + WARM_ONE;
    end
  end

  // Per-pin function decode; unknown codes and code 0 select nothing
  logic [NUM_DI-1:0] ackSel;
  logic [NUM_DI-1:0] posSel;
  logic [NUM_DI-1:0] negSel;
  logic [NUM_DI-1:0] stopSel;
  logic [NUM_DI-1:0] wipeSel;
  logic [NUM_DI-1:0] refSel;

  assign ackSel  = diMatch(diCode, DI_ALARM_CLEAR);
  assign posSel  = diMatch(diCode, DI_POS_LIMIT);
  assign negSel  = diMatch(diCode, DI_NEG_LIMIT);
  assign stopSel = diMatch(diCode, DI_ESTOP);
  assign wipeSel = diMatch(diCode, DI_DEV_WIPE);
  assign refSel  = diMatch(diCode, DI_HOME_REF);

  // Function levels: several pins on one function are ORed
  logic ackLvl;
  logic stopLvl;
  logic wipeLvl;
  logic refLvl;

  assign ackLvl  = |(ackSel & pinSync_q);
  assign stopLvl = |(stopSel & pinSync_q);
  assign wipeLvl = |(wipeSel & pinSync_q);
  assign refLvl  = |(refSel & pinSync_q);

  // Function history for edge detection; re-coding a pin that is
  // already ON raises its function level and counts as an edge
  logic ackLvl_q;
  logic stopLvl_q;
  logic wipeLvl_q;
  logic refLvl_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ackLvl_q  <= PIN_RST;
      stopLvl_q <= PIN_RST;
      wipeLvl_q <= PIN_RST;
      refLvl_q  <= PIN_RST;
    end else if (clkEn) begin
      ackLvl_q  <= ackLvl;
      stopLvl_q <= stopLvl;
      wipeLvl_q <= wipeLvl;
      refLvl_q  <= refLvl;
    end
  end

  logic ackRise;
  logic stopRise;
  logic wipeRise;
  logic refRise;

  // The stop edge is never masked, so a stop held through reset still
  // captures the configured stop mode
  assign ackRise  = riseOf(ackLvl, ackLvl_q, primed);
  assign stopRise = riseOf(stopLvl, stopLvl_q, 1'b1);
  assign wipeRise = riseOf(wipeLvl, wipeLvl_q, primed);
  assign refRise  = riseOf(refLvl, refLvl_q, primed);

  // Alarm clear request
  // Edge and alarm state are judged in the same cycle
  logic alarmClear_d;

  assign alarmClear_d = ackRise & coreStat.alarmActive
                      & coreStat.alarmClearable;

  // Travel limits: all assigned pins must be ON to allow a direction;
  // with no pin assigned the direction is free
  // A broken wire to a normally closed switch reads OFF and so blocks
  logic posAll;
  logic negAll;
  logic ignoreLimits;
  logic posAllowed_d;
  logic negAllowed_d;

  assign posAll       = &(pinSync_q | ~posSel);
  assign negAll       = &(pinSync_q | ~negSel);
  assign ignoreLimits = (param.limitIgnoreParam == LIMIT_IGNORE);
  assign posAllowed_d = ignoreLimits | posAll;
  assign negAllowed_d = ignoreLimits | negAll;

  // Emergency stop: mode captured when the stop starts, held until release
  // so that a parameter change cannot alter a stop under way
  logic [ESTOP_MODE_W-1:0] estopMode_d;
  logic [ESTOP_MODE_W-1:0] estopMode_q;

  assign estopMode_d = stopRise ? param.estopModeParam :
                       stopLvl  ? estopMode_q          :
                                  param.estopModeParam;

  // Deviation wipe: edge in mode 1, level in any other mode
  logic devEdgeMode;
  logic devWipe_d;

  assign devEdgeMode = (param.deviationClearModeParam == DEV_CLEAR_EDGE);
  assign devWipe_d   = devEdgeMode ? wipeRise : wipeLvl;

  // Control requests to the drive core
  // Every request is registered so the core never sees decode glitches
  logic                    alarmClear_q;
  logic                    posAllowed_q;
  logic                    negAllowed_q;
  logic                    estopStop_q;
  logic                    devWipe_q;
  logic                    homeRefLevel_q;
  logic                    homeRefEdge_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      alarmClear_q   <= PULSE_RST;
      posAllowed_q   <= ALLOW_RST;
      negAllowed_q   <= ALLOW_RST;
      estopStop_q    <= PULSE_RST;
      estopMode_q    <= EMODE_RST;
      devWipe_q      <= PULSE_RST;
      homeRefLevel_q <= PULSE_RST;
      homeRefEdge_q  <= PULSE_RST;
    end else if (clkEn) begin
      alarmClear_q   <= alarmClear_d;
      posAllowed_q   <= posAllowed_d;
      negAllowed_q   <= negAllowed_d;
      estopStop_q    <= stopLvl;
      estopMode_q    <= estopMode_d;
      devWipe_q      <= devWipe_d;
      homeRefLevel_q <= refLvl;
      homeRefEdge_q  <= refRise;
    end
  end

  assign coreCtrl.alarmClear   = alarmClear_q;
  assign coreCtrl.posAllowed   = posAllowed_q;
  assign coreCtrl.negAllowed   = negAllowed_q;
  assign coreCtrl.estopStop    = estopStop_q;
  assign coreCtrl.estopMode    = estopMode_q;
  assign coreCtrl.devWipe      = devWipe_q;
  assign coreCtrl.homeRefLevel = homeRefLevel_q;
  assign coreCtrl.homeRefEdge  = homeRefEdge_q;

  // Output pins and code checks
  logic [NUM_DO-1:0] doPin_d;
  logic [NUM_DO-1:0] doPin_q;
  logic [NUM_DO-1:0] doBad_d;
  logic [NUM_DO-1:0] doBad_q;
  logic [NUM_DI-1:0] diBad_d;
  logic [NUM_DI-1:0] diBad_q;

  for (genvar o = 0; o < NUM_DO; o++) begin : g_do
    assign doPin_d[o] = doLevel(doCode[o], coreStat);
    assign doBad_d[o] = ~doKnown(doCode[o]);
  end

  for (genvar d = 0; d < NUM_DI; d++) begin : g_di
    assign diBad_d[d] = ~diKnown(diCode[d]);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      doPin_q <= {NUM_DO{PIN_RST}};
      doBad_q <= {NUM_DO{PIN_RST}};
      diBad_q <= {NUM_DI{PIN_RST}};
    end else if (clkEn) begin
      doPin_q <= doPin_d;
      doBad_q <= doBad_d;
      diBad_q <= diBad_d;
    end
  end

  assign doPin     = doPin_q;
  assign doCodeBad = doBad_q;
  assign diCodeBad = diBad_q;
  assign diState   = pinSync_q;

endmodule : sdm_func_map

// ---- hdl/sdm_pkg.sv ----
/*
  Constants, function codes and carrier types for the servo digital
  input / output function map.
  Assumes one drive clock and a synchronous reset; the control core
  and the parameter store sit on the same clock as this block.
*/
package sdm_pkg;

  localparam int DI_COUNT     = 5;
  localparam int DO_COUNT     = 4;
  localparam int CODE_W       = 5;
  localparam int ESTOP_MODE_W = 2;
  localparam int DEV_MODE_W   = 4;
  localparam int WARM_W       = 2;

  typedef logic [CODE_W-1:0] sdm_code_t;

  // Input function codes
  localparam sdm_code_t DI_NONE        = 5'h00;
  localparam sdm_code_t DI_ALARM_CLEAR = 5'h02;
  localparam sdm_code_t DI_POS_LIMIT   = 5'h03;
  localparam sdm_code_t DI_NEG_LIMIT   = 5'h04;
  localparam sdm_code_t DI_ESTOP       = 5'h0f;
  localparam sdm_code_t DI_DEV_WIPE    = 5'h14;
  localparam sdm_code_t DI_HOME_REF    = 5'h18;

  // Output function codes
  localparam sdm_code_t DO_FORCE_OFF   = 5'h00;
  localparam sdm_code_t DO_FORCE_ON    = 5'h01;
  localparam sdm_code_t DO_READY       = 5'h02;
  localparam sdm_code_t DO_FAULT_FLAG  = 5'h03;
  localparam sdm_code_t DO_HOLD_BRAKE  = 5'h08;
  localparam sdm_code_t DO_RUNNING     = 5'h09;
  localparam sdm_code_t DO_TORQUE_CAP  = 5'h0b;
  localparam sdm_code_t DO_SPEED_CAP   = 5'h0c;
  localparam sdm_code_t DO_HOME_DONE   = 5'h0d;
  localparam sdm_code_t DO_DYN_BRAKE   = 5'h1e;

  // Parameter values
  localparam logic                  LIMIT_IGNORE   = 1'h1;
  localparam logic [DEV_MODE_W-1:0] DEV_CLEAR_EDGE = 4'h1;

  // Cycle counts: enabled cycles after reset before pin edges other than the stop edge count
  localparam logic [WARM_W-1:0] WARM_CYCLES = 2'h3;
  localparam logic [WARM_W-1:0] WARM_ONE    = 2'h1;

  // Values after reset
  localparam logic                    PIN_RST   = 1'h0;
  localparam logic                    PULSE_RST = 1'h0;
  localparam logic                    ALLOW_RST = 1'h0;
  localparam logic [ESTOP_MODE_W-1:0] EMODE_RST = 2'h0;
  localparam logic [WARM_W-1:0]       WARM_RST  = 2'h0;

  typedef struct packed {
    logic                    limitIgnoreParam;
    logic [ESTOP_MODE_W-1:0] estopModeParam;
    logic [DEV_MODE_W-1:0]   deviationClearModeParam;
  } sdm_param_t;

  typedef struct packed {
    logic mainPowerOk;
    logic alarmActive;
    logic alarmClearable;
    logic brakeRelease;
    logic motorRunning;
    logic torqueAtLimit;
    logic speedAtLimit;
    logic torqueCtrlMode;
    logic homingDone;
    logic dynBrakeReq;
  } sdm_core_stat_t;

  typedef struct packed {
    logic                    alarmClear;
    logic                    posAllowed;
    logic                    negAllowed;
    logic                    estopStop;
    logic [ESTOP_MODE_W-1:0] estopMode;
    logic                    devWipe;
    logic                    homeRefLevel;
    logic                    homeRefEdge;
  } sdm_core_ctrl_t;

endpackage : sdm_pkg

// ---- verification/sdm_func_map_assertions.sv ----
/* Port checker for the function map.
   Assumes only pin 0 ever carries input codes 2 and 20. */
module sdm_func_map_assertions
  import sdm_pkg::*;
#(
  parameter int NUM_DI = DI_COUNT,
  parameter int NUM_DO = DO_COUNT
) (
  input wire logic                          core_clk,
  input wire logic                          sys_rst,
  input wire logic                          clkEn,
  input wire logic [NUM_DI-1:0]             diPin,
  input wire logic [NUM_DI-1:0][CODE_W-1:0] diCode,
  input wire logic [NUM_DO-1:0][CODE_W-1:0] doCode,
  input wire sdm_param_t                    param,
  input wire sdm_core_stat_t                coreStat,
  input wire logic [NUM_DO-1:0]             doPin,
  input wire sdm_core_ctrl_t                coreCtrl,
  input wire logic [NUM_DI-1:0]             diState,
  input wire logic [NUM_DI-1:0]             diCodeBad,
  input wire logic [NUM_DO-1:0]             doCodeBad
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Enabled cycles since reset; pin edges other than the stop edge count only once this is full
  logic [WARM_W-1:0] warmCnt;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      warmCnt <= WARM_RST;
    end else if (clkEn && warmCnt != WARM_CYCLES) begin
      warmCnt <= warmCnt + WARM_ONE;
    end
  end
  sequence s_ack_edge;
    clkEn && warmCnt == WARM_CYCLES && diCode[0] == DI_ALARM_CLEAR &&
      $rose(diState[0]) && coreStat.alarmActive && coreStat.alarmClearable;
  endsequence
  sequence s_ack_pulse;
    $rose(coreCtrl.alarmClear);
  endsequence
  a_clear_pulse: assert property (s_ack_edge |=> coreCtrl.alarmClear)
    else $error("alarm clear pulse missing");
  a_clear_guard: assert property (s_ack_pulse |->
    $past(coreStat.alarmActive && coreStat.alarmClearable))
    else $error("alarm clear without clearable alarm");
  a_ready_out: assert property (clkEn && doCode[0] == DO_READY |=>
    doPin[0] == $past(coreStat.mainPowerOk && !coreStat.alarmActive))
    else $error("ready output wrong");
  a_force_on: assert property (clkEn && doCode[1] == DO_FORCE_ON |=> doPin[1])
    else $error("forced output not on");
  a_speed_cap: assert property (clkEn && doCode[2] == DO_SPEED_CAP |=>
    doPin[2] == $past(coreStat.torqueCtrlMode && coreStat.speedAtLimit))
    else $error("speed cap output wrong");
  a_limit_ignore: assert property (clkEn && param.limitIgnoreParam |=>
    coreCtrl.posAllowed && coreCtrl.negAllowed)
    else $error("ignored limit still blocks");
  a_pos_block: assert property (clkEn && !param.limitIgnoreParam &&
    diCode[0] == DI_POS_LIMIT && !diState[0] |=> !coreCtrl.posAllowed)
    else $error("positive limit not blocking");
  a_neg_block: assert property (clkEn && !param.limitIgnoreParam &&
    diCode[1] == DI_NEG_LIMIT && !diState[1] |=> !coreCtrl.negAllowed)
    else $error("negative limit not blocking");
  a_estop_on: assert property (clkEn && diCode[0] == DI_ESTOP && diState[0] |=>
    coreCtrl.estopStop)
    else $error("emergency stop not raised");
  a_wipe_edge: assert property (clkEn && coreCtrl.devWipe &&
    param.deviationClearModeParam == DEV_CLEAR_EDGE |=> !coreCtrl.devWipe)
    else $error("edge wipe longer than one cycle");
endmodule : sdm_func_map_assertions

bind sdm_func_map sdm_func_map_assertions #(.NUM_DI(NUM_DI), .NUM_DO(NUM_DO)) u_chk (
  .core_clk, .sys_rst, .clkEn, .diPin, .diCode, .doCode, .param, .coreStat,
  .doPin, .coreCtrl, .diState, .diCodeBad, .doCodeBad
);

// ---- verification/sdm_switch_model.sv ----
/* Machine-side model: limit switches, stop button and controller
   contacts that drive the input pins. Assumes the bench actuates them. */
module sdm_switch_model
  import sdm_pkg::*;
(
  input  wire logic [DI_COUNT-1:0] press,
  input  wire logic [DI_COUNT-1:0] nc,
  output wire logic [DI_COUNT-1:0] diPin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Contacts move off the clock; a normally closed contact reads ON at rest
  assign #2 diPin = press ^ nc;
endmodule : sdm_switch_model

// ---- verification/test_servo_di_do_function_map.sv ----
/* Self-checking bench: random pins, codes and status against a model.
   Assumes the switch model and the bound checker are compiled first. */
module test_servo_di_do_function_map
  import sdm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, sys_rst = 1, clkEn = 1;
  logic [4:0] press = '0, nc = '0, m1, m2, eBad;
  wire  [4:0] diPin;
  logic [4:0][4:0] diCode = '0;
  logic [3:0][4:0] doCode = '0;
  sdm_param_t param = '0;
  sdm_core_stat_t coreStat = '0;
  logic [3:0] doPin, doCodeBad, eDo, eDoBad;
  logic [4:0] diState, diCodeBad;
  sdm_core_ctrl_t coreCtrl, eCtl;
  logic p2, p20, p24;
  logic [WARM_W-1:0] wm;
  int n_fail = 0, tests_run = 0, cyc = 0;
  int diTab[$] = '{0, 2, 3, 4, 15, 20, 24, 7};
  int loTab[$] = '{0, 3, 4, 15, 24, 7};
  int doTab[$] = '{0, 1, 2, 3, 8, 9, 11, 12, 13, 30, 5};

  sdm_switch_model sw (.press, .nc, .diPin);
  sdm_func_map dut (.core_clk, .sys_rst, .clkEn, .diPin, .diCode, .doCode, .param,
    .coreStat, .doPin, .coreCtrl, .diState, .diCodeBad, .doCodeBad);

  always #5 core_clk = ~core_clk;

  function automatic logic hit(int c, logic v);
    hit = 0;
    for (int k = 0; k < 5; k++) if (diCode[k] == c && m2[k] == v) hit = 1;
  endfunction : hit

  function automatic logic dov(int c);
    case (c)
      1: dov = 1;
      2: dov = coreStat.mainPowerOk && !coreStat.alarmActive;
      3: dov = !coreStat.alarmActive;
      8: dov = coreStat.brakeRelease;
      9: dov = coreStat.motorRunning;
      11: dov = coreStat.torqueAtLimit;
      12: dov = coreStat.torqueCtrlMode && coreStat.speedAtLimit;
      13: dov = coreStat.homingDone;
      30: dov = coreStat.dynBrakeReq;
      default: dov = 0;
    endcase
  endfunction : dov

  always @(posedge core_clk) begin
    if (sys_rst) begin
      {m1, m2, eBad, eDo, eDoBad, eCtl, p2, p20, p24, wm} <= '0;
    end else if (clkEn) begin
      for (int j = 0; j < 4; j++) begin
        eDo[j] <= dov(doCode[j]);
        eDoBad[j] <= !(int'(doCode[j]) inside {0, 1, 2, 3, 8, 9, 11, 12, 13, 30});
      end
      for (int k = 0; k < 5; k++) eBad[k] <= !(int'(diCode[k]) inside {0, 2, 3, 4, 15, 20, 24});
      eCtl.alarmClear <= hit(2, 1) && !p2 && wm == WARM_CYCLES
                         && coreStat.alarmActive && coreStat.alarmClearable;
      eCtl.posAllowed <= param.limitIgnoreParam || !hit(3, 0);
      eCtl.negAllowed <= param.limitIgnoreParam || !hit(4, 0);
      if (!(eCtl.estopStop && hit(15, 1))) eCtl.estopMode <= param.estopModeParam;
      eCtl.estopStop <= hit(15, 1);
      eCtl.devWipe <= hit(20, 1) && !(param.deviationClearModeParam == 1
                      && (p20 || wm != WARM_CYCLES));
      eCtl.homeRefLevel <= hit(24, 1);
      eCtl.homeRefEdge <= hit(24, 1) && !p24 && wm == WARM_CYCLES;
      p2 <= hit(2, 1);
      p20 <= hit(20, 1);
      p24 <= hit(24, 1);
      if (wm != WARM_CYCLES) wm <= wm + WARM_ONE;
      m2 <= m1;
      m1 <= diPin;
    end
  end

  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic chk_do(input logic [3:0] g, input logic [3:0] e);
    cmp(16'(g), 16'(e));
  endtask : chk_do
  task automatic chk_ctrl(input sdm_core_ctrl_t g, input sdm_core_ctrl_t e);
    cmp(16'(g), 16'(e));
  endtask : chk_ctrl
  task automatic chk_di(input logic [13:0] g, input logic [13:0] e);
    cmp(16'(g), 16'(e));
  endtask : chk_di

  always @(negedge core_clk) begin
    chk_do(doPin, eDo);
    chk_ctrl(coreCtrl, eCtl);
    chk_di({diState, diCodeBad, doCodeBad}, {m2, eBad, eDoBad});
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      finish_test();
    end
  end

  initial begin
    void'($urandom(16));
    repeat (2) @(posedge core_clk);
    sys_rst <= 0;
    for (int t = 0; t < 4; t++) begin
      nc <= 5'($urandom);
      param.limitIgnoreParam <= t[0];
      for (int i = 0; i < 500; i++) begin
        @(posedge core_clk);
        sys_rst <= (t == 2 && (i == 200 || i == 201));
        press <= 5'($urandom);
        coreStat <= sdm_core_stat_t'(10'($urandom));
        clkEn <= ($urandom % 8) != 0;
        if ($urandom % 16 == 0) begin
          diCode[0] <= 5'(diTab[$urandom % 8]);
          for (int k = 1; k < 5; k++) diCode[k] <= 5'(loTab[$urandom % 6]);
          for (int j = 0; j < 4; j++) doCode[j] <= 5'(doTab[$urandom % 11]);
          param.estopModeParam <= 2'($urandom);
          param.deviationClearModeParam <= 4'($urandom % 3);
        end
      end
      $display("test %0d done, mismatches %0d", t, n_fail);
    end
    finish_test();
  end
endmodule : test_servo_di_do_function_map
